// File: design/vtp_pattern_ctl.v
// Purpose: test pattern generator control with AHB-Lite registers and video path
// Assumes: ramp regions of at least 256 pixels or lines; one clock domain
// Notes: pixels carry start-of-frame and end-of-line flags for timing
`include "vtp_pattern_regs.vh"

module vtp_pattern_ctl #(
  parameter H_ACTIVE = 1920,
  parameter V_ACTIVE = 1080
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  // Received video in
  input wire vidInValid,
  output wire vidInReady,
  input wire [23:0] vidInData,
  input wire vidInSof,
  input wire vidInEol,
  // Video out
  output wire vidOutValid,
  input wire vidOutReady,
  output wire [23:0] vidOutData,
  output wire vidOutSof,
  output wire vidOutEol,
  // Loop-through driver control
  output wire loopTxPowerdown
);
  // Read handshake states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_READ = 2'b10;

  reg [7:0] loopCtl_reg;
  reg [7:0] patCtl_reg;
  reg [7:0] patCfg_reg;
  reg [7:0] custRed_reg;
  reg [7:0] custGreen_reg;
  reg [7:0] custBlue_reg;
  reg [7:0] frameTime_reg;
  reg [1:0] state_reg;
  reg wrPend_reg;
  reg [7:0] wrIdx_reg;
  reg [7:0] rdIdx_reg;
  reg [31:0] hrdata_reg;
  reg [11:0] xCnt_reg;
  reg [11:0] yCnt_reg;
  reg [17:0] hAcc_reg;
  reg [17:0] vAcc_reg;
  reg [7:0] hLev_reg;
  reg [7:0] vLev_reg;
  reg [3:0] scrollSel_reg;
  reg [7:0] frameCnt_reg;
  reg [7:0] readValue;
  reg [23:0] pixel;
  reg [23:0] basePixel;
  reg [11:0] xBase;
  reg [11:0] yBase;
  reg [17:0] hAccBase;
  reg [17:0] vAccBase;
  reg [7:0] hLevBase;
  reg [7:0] vLevBase;
  reg [11:0] xCnt_next;
  reg [11:0] yCnt_next;
  reg [17:0] hAcc_next;
  reg [17:0] vAcc_next;
  reg [7:0] hLev_next;
  reg [7:0] vLev_next;
  reg [17:0] hSum;
  reg [17:0] vSum;
  wire addrPhase;
  wire genEnable;
  wire autoScroll;
  wire invert;
  wire [3:0] activeSel;
  wire pixTaken;
  wire bufInReady;
  wire [25:0] bufInData;
  wire [25:0] bufOutData;
  wire [3:0] hRampIdx;
  wire [3:0] vRampIdx;

  // Region sizes cut to the accumulator width on purpose
  localparam [31:0] H_ACT_FULL = H_ACTIVE;
  localparam [31:0] V_ACT_FULL = V_ACTIVE;
  localparam [17:0] H_ACT = H_ACT_FULL[17:0];
  localparam [17:0] V_ACT = V_ACT_FULL[17:0];

  // Colour of a bar by index, used by the colour bars only; bands pick colours directly
  function [23:0] barColor;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: barColor = `VTP_WHITE;
        3'h1: barColor = `VTP_YELLOW;
        3'h2: barColor = `VTP_CYAN;
        3'h3: barColor = `VTP_GREEN;
        3'h4: barColor = `VTP_MAGENTA;
        3'h5: barColor = `VTP_RED;
        3'h6: barColor = `VTP_BLUE;
        default: barColor = `VTP_BLACK;
      endcase
    end
  endfunction

  // Ramp colour toward white or a primary
  function [23:0] rampColor;
    input [1:0] tint;
    input [7:0] lev;
    begin
      case (tint)
        2'h0: rampColor = {lev, lev, lev};
        2'h1: rampColor = {lev, 8'h00, 8'h00};
        2'h2: rampColor = {8'h00, lev, 8'h00};
        default: rampColor = {8'h00, 8'h00, lev};
      endcase
    end
  endfunction

  // Control fields
  assign loopTxPowerdown = loopCtl_reg[`VTP_BIT_TX_PWDN]; // [R1]
  assign genEnable = patCtl_reg[`VTP_BIT_GEN_EN]; // [R3]
  assign autoScroll = patCfg_reg[`VTP_BIT_ASCRL];
  assign invert = patCfg_reg[`VTP_BIT_INV];
  assign activeSel = autoScroll ? scrollSel_reg : patCtl_reg[`VTP_SEL_HI:`VTP_SEL_LO]; // [R5]
  // Ramp tint index from the first code of each ramp group
  assign hRampIdx = activeSel - `VTP_SEL_HRAMP;
  assign vRampIdx = activeSel - `VTP_SEL_VRAMP;

  // Bus answers: reads wait one cycle, writes none
  assign addrPhase = hsel & htrans[1] & hready;
  assign hreadyout = (state_reg != ST_READ);
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;

  // Read mux
  always @* begin
    case (rdIdx_reg)
      `VTP_IDX_LOOP_CTL3: readValue = loopCtl_reg;
      `VTP_IDX_PAT_CTL: readValue = patCtl_reg;
      `VTP_IDX_PAT_CFG: readValue = patCfg_reg;
      `VTP_IDX_CUST_RED: readValue = custRed_reg;
      `VTP_IDX_CUST_GREEN: readValue = custGreen_reg;
      `VTP_IDX_CUST_BLUE: readValue = custBlue_reg;
      `VTP_IDX_FRAME_TIME: readValue = frameTime_reg;
      `VTP_IDX_STATUS: readValue = {3'h0, genEnable, activeSel};
      default: readValue = 8'h00;
    endcase
  end

  // Bus state, address capture and read data
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      wrPend_reg <= 1'b0;
      wrIdx_reg <= 8'h00;
      rdIdx_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          wrPend_reg <= addrPhase & hwrite;
          if (addrPhase) begin
            wrIdx_reg <= haddr[9:2];
            rdIdx_reg <= haddr[9:2];
            if (!hwrite) begin
              state_reg <= ST_READ;
            end
          end
        end
        ST_READ: begin
          wrPend_reg <= 1'b0;
          hrdata_reg <= {24'h000000, readValue};
          state_reg <= ST_IDLE;
        end
        default: begin
          wrPend_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Register writes in the data phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loopCtl_reg <= `VTP_RST_LOOP_CTL3;
      patCtl_reg <= `VTP_RST_PAT_CTL; // [R4]
      patCfg_reg <= `VTP_RST_PAT_CFG;
      custRed_reg <= `VTP_RST_CUST;
      custGreen_reg <= `VTP_RST_CUST;
      custBlue_reg <= `VTP_RST_CUST;
      frameTime_reg <= `VTP_RST_FRAME_TIME;
    end else if (wrPend_reg) begin
      case (wrIdx_reg)
        `VTP_IDX_LOOP_CTL3: loopCtl_reg <= hwdata[7:0]; // [R1]
        `VTP_IDX_PAT_CTL: patCtl_reg <= hwdata[7:0]; // [R3] [R4]
        `VTP_IDX_PAT_CFG: patCfg_reg <= hwdata[7:0] & `VTP_CFG_RW_MASK;
        `VTP_IDX_CUST_RED: custRed_reg <= hwdata[7:0];
        `VTP_IDX_CUST_GREEN: custGreen_reg <= hwdata[7:0];
        `VTP_IDX_CUST_BLUE: custBlue_reg <= hwdata[7:0];
        `VTP_IDX_FRAME_TIME: frameTime_reg <= hwdata[7:0];
        default: frameTime_reg <= frameTime_reg;
      endcase
    end
  end

  // Video handshake through the buffer
  assign vidInReady = bufInReady;
  assign pixTaken = vidInValid & bufInReady;

  // Position of the current pixel; start of frame restarts all
  always @* begin
    xBase = vidInSof ? 12'h000 : xCnt_reg;
    yBase = vidInSof ? 12'h000 : yCnt_reg;
    hAccBase = vidInSof ? 18'h00000 : hAcc_reg;
    vAccBase = vidInSof ? 18'h00000 : vAcc_reg;
    hLevBase = vidInSof ? 8'h00 : hLev_reg;
    vLevBase = vidInSof ? 8'h00 : vLev_reg;
    hSum = hAccBase + `VTP_RAMP_STEPS;
    vSum = vAccBase + `VTP_RAMP_STEPS;
    xCnt_next = xBase + 12'h001;
    yCnt_next = yBase;
    hAcc_next = hSum;
    vAcc_next = vAccBase;
    hLev_next = hLevBase;
    vLev_next = vLevBase;
    // Even steps: one level each time the accumulator passes the region size
    if (hSum >= H_ACT) begin
      hAcc_next = hSum - H_ACT; // [R9]
      hLev_next = (hLevBase == 8'hFF) ? hLevBase : hLevBase + 8'h01;
    end
    if (vidInEol) begin
      xCnt_next = 12'h000;
      hAcc_next = 18'h00000;
      hLev_next = 8'h00;
      yCnt_next = yBase + 12'h001;
      vAcc_next = vSum;
      if (vSum >= V_ACT) begin
        vAcc_next = vSum - V_ACT; // [R9]
        vLev_next = (vLevBase == 8'hFF) ? vLevBase : vLevBase + 8'h01;
      end
    end
  end

  // Position counters
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xCnt_reg <= 12'h000;
      yCnt_reg <= 12'h000;
      hAcc_reg <= 18'h00000;
      vAcc_reg <= 18'h00000;
      hLev_reg <= 8'h00;
      vLev_reg <= 8'h00;
    end else if (pixTaken) begin
      xCnt_reg <= xCnt_next;
      yCnt_reg <= yCnt_next;
      hAcc_reg <= hAcc_next;
      vAcc_reg <= vAcc_next;
      hLev_reg <= hLev_next;
      vLev_reg <= vLev_next;
    end
  end

  // Auto-scroll: count frames, then step to the next valid code
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scrollSel_reg <= `VTP_SEL_FIRST;
      frameCnt_reg <= 8'h00;
    end else if (!autoScroll) begin
      scrollSel_reg <= patCtl_reg[`VTP_SEL_HI:`VTP_SEL_LO]; // [R14]
      frameCnt_reg <= 8'h00;
    end else if (pixTaken && vidInSof) begin
      if (frameCnt_reg + 8'h01 >= frameTime_reg) begin
        frameCnt_reg <= 8'h00;
        if (scrollSel_reg >= `VTP_SEL_LAST || scrollSel_reg < `VTP_SEL_FIRST) begin
          scrollSel_reg <= `VTP_SEL_FIRST; // [R14]
        end else begin
          scrollSel_reg <= scrollSel_reg + 4'h1; // [R14]
        end
      end else begin
        frameCnt_reg <= frameCnt_reg + 8'h01;
      end
    end
  end

  // Pattern choice in priority order, then inversion
  always @* begin
    if (patCtl_reg[`VTP_BIT_COMPLY]) begin
      // Pixel checkerboard for the compliance pattern
      basePixel = (xBase[0] ^ yBase[0]) ? `VTP_WHITE : `VTP_BLACK; // [R11] [R16]
    end else if (patCtl_reg[`VTP_BIT_BARS]) begin
      basePixel = barColor(hLevBase[7:5]); // [R12] [R16]
    end else begin
      case (activeSel) // [R11]
        4'h1: basePixel = `VTP_WHITE; // [R6]
        4'h2: basePixel = `VTP_BLACK; // [R6]
        4'h3: basePixel = `VTP_RED; // [R6]
        4'h4: basePixel = `VTP_GREEN; // [R6]
        4'h5: basePixel = `VTP_BLUE; // [R6]
        4'h6, 4'h7, 4'h8, 4'h9: begin
          basePixel = rampColor(hRampIdx[1:0], hLevBase); // [R7]
        end
        4'hA, 4'hB, 4'hC, 4'hD: begin
          basePixel = rampColor(vRampIdx[1:0], vLevBase); // [R8]
        end
        `VTP_SEL_CUSTOM: basePixel = {custRed_reg, custGreen_reg, custBlue_reg}; // [R10]
        default: begin
          // Reserved codes: four bands in place of an undefined pattern
          case (hLevBase[7:6]) // [R13]
            2'h0: basePixel = patCtl_reg[`VTP_BIT_BAND_REV] ? `VTP_BLUE : `VTP_YELLOW;
            2'h1: basePixel = `VTP_CYAN;
            2'h2: basePixel = patCtl_reg[`VTP_BIT_BAND_REV] ? `VTP_YELLOW : `VTP_BLUE;
            default: basePixel = `VTP_RED;
          endcase
        end
      endcase
    end
    // Inversion then substitution of received video
    if (genEnable) begin
      pixel = invert ? ~basePixel : basePixel; // [R15] [R6] [R7] [R8]
    end else begin
      pixel = vidInData; // [R17]
    end
  end

  assign bufInData = {vidInSof, vidInEol, pixel}; // [R17]

  // Two-entry buffer toward the video output
  vtp_skid_buffer #(
    .WIDTH(26)
  ) outBuf (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(vidInValid),
    .inReady(bufInReady),
    .inData(bufInData),
    .outValid(vidOutValid),
    .outReady(vidOutReady),
    .outData(bufOutData)
  );

  assign vidOutSof = bufOutData[25];
  assign vidOutEol = bufOutData[24];
  assign vidOutData = bufOutData[23:0];
endmodule // vtp_pattern_ctl

// File: common/vtp_pattern_regs.vh
// What this block does
// R1 - Loop-through driver control bit 0: 0 powers the transmit driver up, 1 down.
// R2 - Software sets the loop-through powerdown bit before enabling the generator.
// R3 - Pattern control bit 0 enables the generator; clear disables it.
// R4 - Pattern control bits 7..4 select fixed pattern, reset 1; 0000, 1111 reserved.
// R5 - Fixed selector is ignored while auto-scroll is enabled.
// R6 - Codes 0001..0101 give solid white, black, red, green, blue; inverted complements.
// R7 - Codes 0110..1001 give horizontal ramps from black toward white or primary.
// R8 - Codes 1010..1101 give vertical ramps from black toward white or primary.
// R9 - Ramp brightness steps spread evenly over the active width or height.
// R10 - Code 1110 outputs the custom colour from red, green, blue registers.
// R11 - Control bit 3 selects the compliance pattern, overriding the selector.
// R12 - Control bit 2 gives colour bars white, yellow, cyan, green, magenta, red, blue, black.
// R13 - Control bit 1 reverses four-band order: yellow,cyan,blue,red or blue,cyan,yellow,red.
// R14 - Auto-scroll advances to the next pattern after the programmed frame count.
// R15 - Invert bit outputs the inverted colour of every selected pattern.
// R16 - Compliance pattern beats colour bars; colour bars beat the fixed selector.
// R17 - Enabled generator replaces received video; disabled passes video unchanged.
//
// Purpose: register indexes, fields, resets and colours of the test pattern block
// Assumes: byte address on the bus is four times the register index
// Notes: header holds definitions only
`ifndef VTP_PATTERN_REGS_VH
`define VTP_PATTERN_REGS_VH

// Register indexes
`define VTP_IDX_LOOP_CTL3 8'h63
`define VTP_IDX_PAT_CTL 8'h64
`define VTP_IDX_PAT_CFG 8'h65
`define VTP_IDX_CUST_RED 8'h6A
`define VTP_IDX_CUST_GREEN 8'h6B
`define VTP_IDX_CUST_BLUE 8'h6C
`define VTP_IDX_FRAME_TIME 8'h6D
`define VTP_IDX_STATUS 8'h6E

// Reset values
`define VTP_RST_LOOP_CTL3 8'h00
`define VTP_RST_PAT_CTL 8'h10
`define VTP_RST_PAT_CFG 8'h00
`define VTP_RST_CUST 8'h00
`define VTP_RST_FRAME_TIME 8'h3C

// Field positions
`define VTP_BIT_TX_PWDN 0
`define VTP_BIT_GEN_EN 0
`define VTP_BIT_BAND_REV 1
`define VTP_BIT_BARS 2
`define VTP_BIT_COMPLY 3
`define VTP_SEL_HI 7
`define VTP_SEL_LO 4
`define VTP_BIT_ASCRL 0
`define VTP_BIT_INV 1
`define VTP_CFG_RW_MASK 8'h1F

// Selector codes
`define VTP_SEL_FIRST 4'h1
`define VTP_SEL_HRAMP 4'h6
`define VTP_SEL_VRAMP 4'hA
`define VTP_SEL_CUSTOM 4'hE
`define VTP_SEL_LAST 4'hE

// Colours, red in the top byte
`define VTP_WHITE 24'hFFFFFF
`define VTP_YELLOW 24'hFFFF00
`define VTP_CYAN 24'h00FFFF
`define VTP_GREEN 24'h00FF00
`define VTP_MAGENTA 24'hFF00FF
`define VTP_RED 24'hFF0000
`define VTP_BLUE 24'h0000FF
`define VTP_BLACK 24'h000000

// Ramp step count per active region
`define VTP_RAMP_STEPS 18'h00100

`endif

// File: design/vtp_skid_buffer.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: data outputs come from the storage flip-flops
module vtp_skid_buffer #(
  parameter WIDTH = 26
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Filling side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Draining side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem0_reg;
  reg [WIDTH-1:0] mem1_reg;
  reg wrPtr_reg;
  reg rdPtr_reg;
  reg [1:0] count_reg;
  wire doPush;
  wire doPop;

  // Honest full and empty
  assign inReady = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData = rdPtr_reg ? mem1_reg : mem0_reg;
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  // Storage and pointers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem0_reg <= {WIDTH{1'b0}};
      mem1_reg <= {WIDTH{1'b0}};
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (doPush) begin
        if (wrPtr_reg) begin
          mem1_reg <= inData;
        end else begin
          mem0_reg <= inData;
        end
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (doPop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      if (doPush && !doPop) begin
        count_reg <= count_reg + 2'h1;
      end else if (doPop && !doPush) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
endmodule // vtp_skid_buffer

// File: tb/vtp_pattern_ctl_chk.sv
// Purpose: port checks for the test pattern control block
// Assumes: byte address is four times the register index
// Notes: bound to the design from the bench top file
`include "vtp_pattern_regs.vh"
module vtp_pattern_ctl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Video in
  input wire logic vidInValid,
  input wire logic vidInReady,
  input wire logic [23:0] vidInData,
  input wire logic vidInSof,
  input wire logic vidInEol,
  // Video out
  input wire logic vidOutValid,
  input wire logic vidOutReady,
  input wire logic [23:0] vidOutData,
  input wire logic vidOutSof,
  input wire logic vidOutEol,
  // Loop-through driver
  input wire logic loopTxPowerdown
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take, loopData_reg, ctlData_reg, en_reg, enOld_reg;
  assign take = hsel && htrans[1] && hready;
  // Shadow data phases and the generator enable bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loopData_reg <= 1'b0;
      ctlData_reg <= 1'b0;
      en_reg <= 1'b0;
      enOld_reg <= 1'b0;
    end else begin
      loopData_reg <= take && hwrite && haddr[9:2] == `VTP_IDX_LOOP_CTL3;
      ctlData_reg <= take && hwrite && haddr[9:2] == `VTP_IDX_PAT_CTL;
      if (ctlData_reg) en_reg <= hwdata[`VTP_BIT_GEN_EN];
      enOld_reg <= en_reg;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Read transfer: address phase, one wait, then data
  sequence rdAddr; take && !hwrite; endsequence
  sequence rdWait; !hreadyout ##1 hreadyout; endsequence
  AST_READ_WAIT: assert property (rdAddr |=> rdWait)
    else $error("read did not take exactly one wait state");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase was stretched");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("slave answered with an error response");
  AST_PWDN_WRITE: assert property (loopData_reg |=> loopTxPowerdown == $past(hwdata[0]))
    else $error("powerdown output does not follow written bit");
  AST_PWDN_HOLD: assert property ($changed(loopTxPowerdown) |-> $past(loopData_reg))
    else $error("powerdown output moved without a write");
  AST_PASS_DATA: assert property (vidInValid && vidInReady && !vidOutValid && !en_reg
    && !enOld_reg |=> vidOutValid && vidOutData == $past(vidInData)
    && vidOutSof == $past(vidInSof) && vidOutEol == $past(vidInEol))
    else $error("disabled generator altered received pixel");
  AST_OUT_HOLD: assert property (vidOutValid && !vidOutReady |=> vidOutValid
    && $stable(vidOutData) && $stable(vidOutSof) && $stable(vidOutEol))
    else $error("stalled output pixel changed");
  AST_EMPTY_READY: assert property (!vidOutValid |-> vidInReady)
    else $error("empty buffer refused a pixel");
  AST_FULL_HOLD: assert property (!vidInReady && !vidOutReady |=> !vidInReady)
    else $error("full buffer accepted without draining");
endmodule // vtp_pattern_ctl_chk

// File: tb/tb_top.sv
// Purpose: self-checking bench for the test pattern control block
// Assumes: 256 by 256 active frame, so ramp level equals position
// Notes: register byte address is four times the index
`include "vtp_pattern_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp, loopTxPowerdown;
  logic vidInValid, vidInReady, vidInSof, vidInEol, vidOutValid, vidOutReady;
  logic vidOutSof, vidOutEol;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [23:0] vidInData, vidOutData;
  logic [7:0] q;
  logic [23:0] oq[$];
  logic [1:0] fq[$];
  int fails, nChecks;
  vtp_pattern_ctl #(.H_ACTIVE(256), .V_ACTIVE(256)) dut (.clk(clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .vidInValid(vidInValid), .vidInReady(vidInReady),
    .vidInData(vidInData), .vidInSof(vidInSof), .vidInEol(vidInEol),
    .vidOutValid(vidOutValid), .vidOutReady(vidOutReady), .vidOutData(vidOutData),
    .vidOutSof(vidOutSof), .vidOutEol(vidOutEol), .loopTxPowerdown(loopTxPowerdown));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Collect pixels leaving the block
  always @(posedge clk) begin
    if (vidOutValid === 1'b1 && vidOutReady === 1'b1) begin
      oq.push_back(vidOutData);
      fq.push_back({vidOutSof, vidOutEol});
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic eq(input logic [23:0] a, input logic [23:0] e, input string m);
    nChecks++;
    if (a !== e) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, a, e);
    end
  endtask
  // Bounded wait on bus ready or video ready
  task automatic waitOn(input logic vid);
    int n;
    n = 0;
    @(posedge clk);
    while ((vid ? vidInReady : hreadyout) !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if ((vid ? vidInReady : hreadyout) !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t wait ran out", $time);
      stop_test;
    end
  endtask
  // One AHB-Lite single transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    waitOn(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitOn(1'b0);
    q = hrdata[7:0];
    @(posedge clk);
  endtask
  task automatic rdChk(input logic [7:0] i, input logic [7:0] e, input string m);
    bus(1'b0, i, 8'h00);
    eq({16'h0, q}, {16'h0, e}, m);
  endtask
  task automatic px(input logic [23:0] d, input logic s, input logic e);
    vidInValid <= 1'b1;
    vidInData <= d;
    vidInSof <= s;
    vidInEol <= e;
    waitOn(1'b1);
  endtask
  // Send one frame start plus n-1 pixels, then let the buffer drain
  task automatic run(input int n, input logic eolAll);
    int i;
    oq.delete();
    fq.delete();
    for (i = 0; i < n; i++) px(24'h5A5A5A, i == 0, eolAll);
    vidInValid <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic t_regs;
    rdChk(`VTP_IDX_LOOP_CTL3, 8'h00, "loop reset");
    rdChk(`VTP_IDX_PAT_CTL, 8'h10, "ctl reset");
    rdChk(`VTP_IDX_PAT_CFG, 8'h00, "cfg reset");
    rdChk(8'h70, 8'h00, "unmapped read");
    bus(1'b1, `VTP_IDX_LOOP_CTL3, 8'h01);
    eq({23'h0, loopTxPowerdown}, 24'h1, "driver down");
    bus(1'b1, `VTP_IDX_LOOP_CTL3, 8'h00);
    eq({23'h0, loopTxPowerdown}, 24'h0, "driver up");
    bus(1'b1, `VTP_IDX_LOOP_CTL3, 8'h01);
    rdChk(`VTP_IDX_LOOP_CTL3, 8'h01, "loop readback");
    $display("regs done");
  endtask
  task automatic t_buf;
    oq.delete();
    fq.delete();
    vidOutReady <= 1'b0;
    px(24'h0000A0, 1'b1, 1'b0);
    px(24'h0000A1, 1'b0, 1'b1);
    @(posedge clk);
    eq({23'h0, vidInReady}, 24'h0, "full refuses");
    vidInValid <= 1'b0;
    vidOutReady <= 1'b1;
    repeat (4) @(posedge clk);
    eq(24'(oq.size()), 24'h2, "drained count");
    eq(oq[0], 24'h0000A0, "first pass");
    eq(oq[1], 24'h0000A1, "second pass");
    eq({22'h0, fq[0]}, 24'h000002, "start flag travels");
    eq({22'h0, fq[1]}, 24'h000001, "line end flag travels");
    $display("buffer done");
  endtask
  task automatic t_fixed;
    logic [23:0] sol[5] = '{`VTP_WHITE, `VTP_BLACK, `VTP_RED, `VTP_GREEN, `VTP_BLUE};
    logic [23:0] msk[4] = '{`VTP_WHITE, `VTP_RED, `VTP_GREEN, `VTP_BLUE};
    logic [23:0] e0, e1;
    int c, v;
    for (v = 0; v < 2; v++) begin
      bus(1'b1, `VTP_IDX_PAT_CFG, {6'h0, v[0], 1'b0});
      for (c = 1; c < 14; c++) begin
        bus(1'b1, `VTP_IDX_PAT_CTL, {c[3:0], 4'h1});
        run(201, c > 9);
        e0 = (c < 6) ? sol[c-1] : 24'h0;
        e1 = (c < 6) ? e0 : (24'hC8C8C8 & msk[(c-6)%4]);
        eq(oq[0], v ? ~e0 : e0, "pattern origin");
        eq(oq[200], v ? ~e1 : e1, "pattern far");
      end
    end
    $display("fixed done");
  endtask
  task automatic t_custom;
    bus(1'b1, `VTP_IDX_CUST_RED, 8'h12);
    bus(1'b1, `VTP_IDX_CUST_GREEN, 8'h34);
    bus(1'b1, `VTP_IDX_CUST_BLUE, 8'h56);
    bus(1'b1, `VTP_IDX_PAT_CTL, 8'hE1);
    run(1, 1'b0);
    eq(oq[0], 24'hEDCBA9, "custom inverted");
    bus(1'b1, `VTP_IDX_PAT_CFG, 8'h00);
    run(1, 1'b0);
    eq(oq[0], 24'h123456, "custom");
    eq({22'h0, fq[0]}, 24'h000002, "flag with generated pixel");
    $display("custom done");
  endtask
  task automatic t_bars;
    logic [23:0] bar[8] = '{`VTP_WHITE, `VTP_YELLOW, `VTP_CYAN, `VTP_GREEN,
      `VTP_MAGENTA, `VTP_RED, `VTP_BLUE, `VTP_BLACK};
    int k;
    bus(1'b1, `VTP_IDX_PAT_CTL, 8'h15);
    run(256, 1'b0);
    for (k = 0; k < 8; k++) eq(oq[32*k+5], bar[k], "colour bar");
    bus(1'b1, `VTP_IDX_PAT_CTL, 8'h1D);
    run(2, 1'b0);
    eq(oq[0], `VTP_BLACK, "compliance even");
    eq(oq[1], `VTP_WHITE, "compliance odd");
    $display("bars done");
  endtask
  task automatic t_band;
    logic [23:0] bd[8] = '{`VTP_YELLOW, `VTP_CYAN, `VTP_BLUE, `VTP_RED,
      `VTP_BLUE, `VTP_CYAN, `VTP_YELLOW, `VTP_RED};
    int r, s, b;
    for (r = 0; r < 2; r++) begin
      for (s = 0; s < 2; s++) begin
        bus(1'b1, `VTP_IDX_PAT_CTL, {s ? 4'hF : 4'h0, 2'h0, r[0], 1'b1});
        run(256, 1'b0);
        for (b = 0; b < 4; b++) eq(oq[64*b], bd[4*r+b], "band");
      end
    end
    $display("band done");
  endtask
  task automatic t_scroll;
    bus(1'b1, `VTP_IDX_FRAME_TIME, 8'h01);
    bus(1'b1, `VTP_IDX_PAT_CTL, 8'h31);
    bus(1'b1, `VTP_IDX_PAT_CFG, 8'h01);
    bus(1'b1, `VTP_IDX_PAT_CTL, 8'h91);
    rdChk(`VTP_IDX_STATUS, 8'h13, "selector ignored");
    run(1, 1'b0);
    rdChk(`VTP_IDX_STATUS, 8'h14, "scroll step");
    bus(1'b1, `VTP_IDX_PAT_CFG, 8'h00);
    rdChk(`VTP_IDX_STATUS, 8'h19, "scroll off");
    $display("scroll done");
  endtask
  // Reset, then the scenarios in order
  initial begin
    reset_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
    hsize = 3'h2;
    {vidInValid, vidInSof, vidInEol, vidInData} = 27'h0;
    vidOutReady = 1'b1;
    fails = 0;
    nChecks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_buf;
    t_fixed;
    t_custom;
    t_bars;
    t_band;
    t_scroll;
    stop_test;
  end
endmodule // tb_top
bind vtp_pattern_ctl vtp_pattern_ctl_chk chk (.clk(clk), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .vidInValid(vidInValid),
  .vidInReady(vidInReady), .vidInData(vidInData), .vidInSof(vidInSof),
  .vidInEol(vidInEol), .vidOutValid(vidOutValid), .vidOutReady(vidOutReady),
  .vidOutData(vidOutData), .vidOutSof(vidOutSof), .vidOutEol(vidOutEol),
  .loopTxPowerdown(loopTxPowerdown));
